// ==== rtl/pos_ref_pkg.sv ====
// constants, modes and setting carriers for position reference conditioning
package pos_ref_pkg;

	// ****************************************
	// timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 10;        // mclk period
	localparam int TICK_TIME_NS  = 100000;    // filter time unit, 0.1 ms
	localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;

	// ****************************************
	// setting limits and factory values
	// ****************************************
	localparam logic [12:0] TC_MAX        = 13'h1900; // 6400 x 0.1 ms
	localparam logic [12:0] TC_RESET      = 13'h0000;
	localparam logic [7:0]  DONE_W_MAX    = 8'hfa;    // 250 reference units
	localparam logic [7:0]  DONE_W_RESET  = 8'h0a;    // 10
	localparam logic [9:0]  JIT_FREQ_MIN  = 10'h00a;  // 1.0 Hz
	localparam logic [9:0]  JIT_FREQ_MAX  = 10'h3e8;  // 100.0 Hz
	localparam logic [9:0]  JIT_FREQ_RESET = 10'h3e8; // 1000 x 0.1 Hz
	localparam logic [7:0]  JIT_DAMP_MAX  = 8'hc8;    // 200
	localparam logic [7:0]  JIT_DAMP_RESET = 8'h19;   // 25

	// ****************************************
	// widths
	// ****************************************
	localparam int ACC_W      = 24;  // filter accumulators and deviation
	localparam int TERM_COUNT = 4;   // output terminals for done routing

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		MODE_SPEED,
		MODE_POSITION,
		MODE_POS_INHIBIT,
		MODE_TORQUE
	} ctrl_mode_e;

	// position side settings
	typedef struct packed {
		ctrl_mode_e  mode;            // control mode
		logic        second_order;    // 1 = second-order smoothing
		logic [12:0] ref_accel_time_const; // 0.1 ms units
		logic [7:0]  done_width;      // reference units
		logic [1:0]  position_done_output_assign; // terminal index
	} pos_cfg_s;

	// low-frequency jitter suppression settings
	typedef struct packed {
		logic       enable;           // 0 = disabled
		logic [9:0] freq;             // 0.1 Hz units
		logic [7:0] damping;
	} jitter_cfg_s;

endpackage

// ==== rtl/position_reference_conditioning.sv ====
// position reference smoothing, completion output, jitter and inhibit control
`timescale 1ns/100ps
module position_reference_conditioning #(
	parameter int TICK_LEN = pos_ref_pkg::TICK_CYCLES  // cycles per 0.1 ms
) (
	input  wire logic                      mclk,
	input  wire logic                      resetn,
	input  wire pos_ref_pkg::pos_cfg_s     pos_cfg,
	input  wire pos_ref_pkg::jitter_cfg_s  jitter_cfg,
	input  wire logic                      ref_pulse_pin,
	input  wire logic                      ref_dir_pin,
	input  wire logic                      deviation_clear_input,
	input  wire logic                      count_hold_input_n,
	input  wire logic                      fb_step,
	input  wire logic                      fb_dir,
	output logic                           pos_step,
	output logic                           pos_dir,
	output logic signed [23:0]             deviation_monitor,
	output logic                           position_done_out,
	output logic [3:0]                     done_terms,
	output logic                           servo_clamp,
	output logic                           jitter_active,
	output logic [9:0]                     jitter_freq_eff,
	output logic [7:0]                     jitter_damp_eff
);
	import pos_ref_pkg::*;

	// ****************************************
	// helpers
	// ****************************************

	// share of a pending count moved per tick, rounded away from zero
	function automatic logic signed [ACC_W-1:0] share(input logic signed [ACC_W-1:0] p,
			input logic [12:0] tc);
		logic [ACC_W-1:0] mag;
		logic [ACC_W-1:0] q;
		mag = p[ACC_W-1] ? ACC_W'(-p) : ACC_W'(p);
		q   = (mag + ACC_W'(tc)) / (ACC_W'(tc) + ACC_W'(1));
		return p[ACC_W-1] ? -$signed(q) : $signed(q);
	endfunction

	// unit step of a given sign, zero when absent
	function automatic logic signed [ACC_W-1:0] unit(input logic valid, input logic dir);
		return !valid ? '0 : (dir ? ACC_W'(1) : -ACC_W'(1));
	endfunction

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic [1:0] sync_pulse;      // reference pulse pin
	logic [1:0] sync_dir;        // reference direction pin
	logic [1:0] sync_clr;        // deviation clear pin
	logic [1:0] sync_hold;       // count hold pin, active low
	logic       pulse_last;      // previous synchronised pulse level

	// two flops per pin, third flop for the pulse edge
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			sync_pulse <= 2'h0;
			sync_dir   <= 2'h0;
			sync_clr   <= 2'h0;
			sync_hold  <= 2'h3;
			pulse_last <= 1'b0;
		end else begin
			sync_pulse <= {sync_pulse[0], ref_pulse_pin};
			sync_dir   <= {sync_dir[0], ref_dir_pin};
			sync_clr   <= {sync_clr[0], deviation_clear_input};
			sync_hold  <= {sync_hold[0], count_hold_input_n};
			pulse_last <= sync_pulse[1];
		end
	end

	// ****************************************
	// mode decode
	// ****************************************
	logic pos_mode;              // any position control mode
	logic inhibit_on;            // inhibit currently active
	logic clr_on;                // clear held by host
	logic ref_edge;              // rising edge on reference pulse
	logic ref_take;              // reference pulse that is counted

	always_comb begin
		pos_mode   = (pos_cfg.mode == MODE_POSITION) || (pos_cfg.mode == MODE_POS_INHIBIT);
		inhibit_on = (pos_cfg.mode == MODE_POS_INHIBIT) && !sync_hold[1];
		clr_on     = sync_clr[1];
		ref_edge   = sync_pulse[1] && !pulse_last;
		ref_take   = ref_edge && pos_mode && !inhibit_on && !clr_on;
	end

	// ****************************************
	// time base
	// ****************************************
	logic [13:0] tick_cnt;       // counts cycles of one 0.1 ms unit
	logic [13:0] next_tick_cnt;
	logic        tick;           // one-cycle enable every 0.1 ms

	// divider for the filter time unit
	always_comb begin
		tick          = (tick_cnt == 14'(TICK_LEN - 1));
		next_tick_cnt = tick ? 14'h0000 : tick_cnt + 14'h0001;
	end

	// register the divider
	always_ff @(posedge mclk) begin
		if (!resetn) tick_cnt <= 14'h0000;
		else         tick_cnt <= next_tick_cnt;
	end

	// ****************************************
	// smoothing filter and deviation counter
	// ****************************************
	logic signed [ACC_W-1:0] stage1;        // pulses waiting in first stage
	logic signed [ACC_W-1:0] stage2;        // pulses waiting in second stage
	logic signed [ACC_W-1:0] credit;        // pulses ready to emit
	logic signed [ACC_W-1:0] deviation;     // reference minus feedback
	logic [12:0]             tc_act;        // time constant in use
	logic signed [ACC_W-1:0] next_stage1;
	logic signed [ACC_W-1:0] next_stage2;
	logic signed [ACC_W-1:0] next_credit;
	logic signed [ACC_W-1:0] next_deviation;
	logic [12:0]             next_tc_act;
	logic                    next_pos_step;
	logic                    next_pos_dir;
	logic [12:0]             tc_req;        // requested constant, clamped

	// pulse flow: input -> stage1 -> stage2 (second order only) -> credit -> emitted step; input straight to credit when the constant is zero
	always_comb begin
		logic signed [ACC_W-1:0] d1;
		logic signed [ACC_W-1:0] d2;
		logic signed [ACC_W-1:0] emit;
		d1             = '0;
		d2             = '0;
		emit           = '0;
		next_stage1    = stage1;
		next_stage2    = stage2;
		next_credit    = credit;
		next_tc_act    = tc_act;
		next_pos_step  = 1'b0;
		next_pos_dir   = pos_dir;
		tc_req = (pos_cfg.ref_accel_time_const > TC_MAX) ? TC_MAX
			: pos_cfg.ref_accel_time_const;
		// one emitted step per cycle while credit remains
		if (credit != '0) begin
			next_pos_step = 1'b1;
			next_pos_dir  = !credit[ACC_W-1];
			emit          = unit(1'b1, !credit[ACC_W-1]);
		end
		next_credit = credit - emit;
		if (tc_act == 13'h0000) begin
			// no smoothing delay
			next_credit = next_credit + stage1 + stage2 + unit(ref_take, sync_dir[1]);
			next_stage1 = '0;
			next_stage2 = '0;
		end else begin
			next_stage1 = stage1 + unit(ref_take, sync_dir[1]);
			if (tick) begin
				d1          = share(stage1, tc_act);
				next_stage1 = next_stage1 - d1;
				if (pos_cfg.second_order) begin
					// cascade gives the s-shaped profile
					d2          = share(stage2, tc_act);
					next_stage2 = stage2 + d1 - d2;
					next_credit = next_credit + d2;
				end else begin
					// single stage, leftover second stage drains straight out
					next_stage2 = '0;
					next_credit = next_credit + d1 + stage2;
				end
			end
		end
		// deviation follows emitted reference against feedback
		next_deviation = deviation + emit - unit(fb_step, fb_dir);
		// new constant only when idle and settled
		if (!ref_edge && deviation == '0 && stage1 == '0 && stage2 == '0 && credit == '0)
			next_tc_act = tc_req;
		// host clear drops all pending movement
		if (clr_on) begin
			next_stage1    = '0;
			next_stage2    = '0;
			next_credit    = '0;
			next_deviation = '0;
			next_pos_step  = 1'b0;
		end
	end

	// register the filter state
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			stage1    <= '0;
			stage2    <= '0;
			credit    <= '0;
			deviation <= '0;
			tc_act    <= TC_RESET;
			pos_step  <= 1'b0;
			pos_dir   <= 1'b0;
		end else begin
			stage1    <= next_stage1;
			stage2    <= next_stage2;
			credit    <= next_credit;
			deviation <= next_deviation;
			tc_act    <= next_tc_act;
			pos_step  <= next_pos_step;
			pos_dir   <= next_pos_dir;
		end
	end

	// ****************************************
	// positioning complete and routing
	// ****************************************
	logic       next_done_n;     // active-low completion
	logic [3:0] next_terms;      // terminal levels
	logic [7:0] width_eff;       // clamped width
	logic       next_clamp;      // servo lock request

	// completion compare and terminal routing
	always_comb begin
		logic [ACC_W-1:0] mag;
		mag         = deviation[ACC_W-1] ? ACC_W'(-deviation) : ACC_W'(deviation);
		width_eff   = (pos_cfg.done_width > DONE_W_MAX) ? DONE_W_MAX : pos_cfg.done_width;
		next_done_n = !(pos_mode && mag <= ACC_W'(width_eff));
		next_terms  = '1;
		next_terms[pos_cfg.position_done_output_assign] = next_done_n;
		next_clamp  = inhibit_on;
	end

	// register completion outputs
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			position_done_out <= 1'b1;
			done_terms        <= 4'hf;
			servo_clamp       <= 1'b0;
		end else begin
			position_done_out <= next_done_n;
			done_terms        <= next_terms;
			servo_clamp       <= next_clamp;
		end
	end

	// ****************************************
	// low-frequency jitter suppression settings
	// ****************************************
	logic       next_jit_act;    // suppression enabled and allowed
	logic [9:0] next_jit_freq;   // clamped target frequency
	logic [7:0] next_jit_damp;   // clamped damping

	// clamp settings; frequency range outside 5..50 Hz is not guaranteed
	always_comb begin
		next_jit_act  = jitter_cfg.enable
			&& (pos_mode || pos_cfg.mode == MODE_SPEED);
		next_jit_freq = (jitter_cfg.freq < JIT_FREQ_MIN) ? JIT_FREQ_MIN
			: (jitter_cfg.freq > JIT_FREQ_MAX) ? JIT_FREQ_MAX : jitter_cfg.freq;
		next_jit_damp = (jitter_cfg.damping > JIT_DAMP_MAX) ? JIT_DAMP_MAX
			: jitter_cfg.damping;
	end

	// register jitter outputs
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			jitter_active   <= 1'b0;
			jitter_freq_eff <= JIT_FREQ_RESET;
			jitter_damp_eff <= JIT_DAMP_RESET;
		end else begin
			jitter_active   <= next_jit_act;
			jitter_freq_eff <= next_jit_freq;
			jitter_damp_eff <= next_jit_damp;
		end
	end

	// monitor copy of the deviation
	assign deviation_monitor = deviation;

endmodule // position_reference_conditioning

// ==== verification/pos_ref_checker.sv ====
// assertions on the ports of position reference conditioning
`timescale 1ns/100ps
module pos_ref_checker (
	input wire logic                     mclk,
	input wire logic                     resetn,
	input wire pos_ref_pkg::pos_cfg_s    pos_cfg,
	input wire pos_ref_pkg::jitter_cfg_s jitter_cfg,
	input wire logic        deviation_clear_input,
	input wire logic        count_hold_input_n,
	input wire logic        fb_step,
	input wire logic        fb_dir,
	input wire logic        pos_step,
	input wire logic signed [23:0] deviation_monitor,
	input wire logic        position_done_out,
	input wire logic [3:0]  done_terms,
	input wire logic        servo_clamp,
	input wire logic        jitter_active,
	input wire logic [9:0]  jitter_freq_eff,
	input wire logic [7:0]  jitter_damp_eff
);
	import pos_ref_pkg::*;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	logic        pos_m, in_win, jit_want; // helper conditions
	logic [1:0]  asg;                     // terminal index
	logic [7:0]  w, dmp;                  // clamped width and damping
	logic [9:0]  frq;                     // clamped frequency
	logic [23:0] mag;                     // deviation magnitude
	// expected settings after clamping
	always_comb begin
		pos_m = pos_cfg.mode inside {MODE_POSITION, MODE_POS_INHIBIT};
		w = (pos_cfg.done_width > DONE_W_MAX) ? DONE_W_MAX : pos_cfg.done_width;
		mag = deviation_monitor[23] ? -deviation_monitor : deviation_monitor;
		in_win = mag <= {16'h0000, w};
		asg = pos_cfg.position_done_output_assign;
		jit_want = jitter_cfg.enable && (pos_cfg.mode != MODE_TORQUE);
		frq = (jitter_cfg.freq < JIT_FREQ_MIN) ? JIT_FREQ_MIN :
			(jitter_cfg.freq > JIT_FREQ_MAX) ? JIT_FREQ_MAX : jitter_cfg.freq;
		dmp = (jitter_cfg.damping > JIT_DAMP_MAX) ? JIT_DAMP_MAX : jitter_cfg.damping;
	end
	sequence s_quiet; (!deviation_clear_input)[*4]; endsequence
	property p_done_on; pos_m && in_win |=> !position_done_out; endproperty
	property p_done_off; !(pos_m && in_win) |=> position_done_out; endproperty
	property p_terms;
		1 |=> done_terms[$past(asg)] == position_done_out && $countones(done_terms) >= 3;
	endproperty
	property p_clamp;
		(pos_cfg.mode == MODE_POS_INHIBIT && !count_hold_input_n)[*5] |-> servo_clamp;
	endproperty
	property p_free; pos_cfg.mode != MODE_POS_INHIBIT |=> !servo_clamp; endproperty
	property p_jit; 1 |=> jitter_active == $past(jit_want); endproperty
	property p_frq; 1 |=> jitter_freq_eff == $past(frq); endproperty
	property p_dmp; 1 |=> jitter_damp_eff == $past(dmp); endproperty
	property p_clr; deviation_clear_input[*5] |-> deviation_monitor == 0 && !pos_step; endproperty
	property p_fb;
		s_quiet ##0 fb_step && fb_dir ##1 !pos_step |->
			deviation_monitor == $past(deviation_monitor) - 24'sh000001;
	endproperty
	property p_step;
		s_quiet ##0 !fb_step ##1 pos_step |->
			deviation_monitor != $past(deviation_monitor);
	endproperty
	a_done_on: assert property (p_done_on) else $error("done not low");
	a_done_off: assert property (p_done_off) else $error("done not high");
	a_terms: assert property (p_terms) else $error("done terminal wrong");
	a_clamp: assert property (p_clamp) else $error("no clamp");
	a_free: assert property (p_free) else $error("stray clamp");
	a_jit: assert property (p_jit) else $error("jitter enable wrong");
	a_frq: assert property (p_frq) else $error("jitter freq wrong");
	a_dmp: assert property (p_dmp) else $error("jitter damping wrong");
	a_clr: assert property (p_clr) else $error("clear ignored");
	a_fb: assert property (p_fb) else $error("feedback not taken");
	a_step: assert property (p_step) else $error("step not counted");
endmodule // pos_ref_checker

bind position_reference_conditioning pos_ref_checker pos_ref_checker_i (.mclk, .resetn,
	.pos_cfg, .jitter_cfg, .deviation_clear_input, .count_hold_input_n, .fb_step, .fb_dir,
	.pos_step, .deviation_monitor, .position_done_out, .done_terms, .servo_clamp,
	.jitter_active, .jitter_freq_eff, .jitter_damp_eff);

// ==== verification/host_pulse_model.sv ====
// host controller model: reference pulse train and clear pin
`timescale 1ns/100ps
module host_pulse_model (
	input  wire logic mclk,
	output logic      ref_pulse_pin,
	output logic      ref_dir_pin,
	output logic      deviation_clear_input
);
	initial begin
		ref_pulse_pin = 1'b0;
		ref_dir_pin = 1'b1;
		deviation_clear_input = 1'b0;
	end
	// direction settles first, each level held 4 cycles
	task automatic send(input int n, input logic d);
		@(negedge mclk) ref_dir_pin = d;
		repeat (n) begin
			repeat (4) @(negedge mclk);
			ref_pulse_pin = 1'b1;
			repeat (4) @(negedge mclk);
			ref_pulse_pin = 1'b0;
		end
	endtask
	// clear held for n cycles to apply a new time constant
	task automatic clear_for(input int n);
		@(negedge mclk) deviation_clear_input = 1'b1;
		repeat (n) @(negedge mclk);
		deviation_clear_input = 1'b0;
	endtask
endmodule // host_pulse_model

// ==== verification/testbench.sv ====
// self-checking bench for position reference conditioning
`timescale 1ns/100ps
module testbench;
	import pos_ref_pkg::*;
	logic mclk, resetn, clr, pls, dir, hold_n, fb_step, fb_dir, pos_step, pos_dir;
	logic done, clamp, jact;
	logic signed [23:0] dev, base;
	logic signed [23:0] net = '0;   // net smoothed steps seen so far
	logic [3:0] terms;
	logic [9:0] jf;
	logic [7:0] jd;
	pos_cfg_s pcfg;
	jitter_cfg_s jcfg;
	int miscompares, samples_checked;
	int cycles = 0;                 // run limit counter
	position_reference_conditioning #(.TICK_LEN(8)) position_reference_conditioning_i (
		.mclk, .resetn, .pos_cfg(pcfg), .jitter_cfg(jcfg), .ref_pulse_pin(pls),
		.ref_dir_pin(dir), .deviation_clear_input(clr), .count_hold_input_n(hold_n),
		.fb_step, .fb_dir, .pos_step, .pos_dir, .deviation_monitor(dev),
		.position_done_out(done), .done_terms(terms), .servo_clamp(clamp),
		.jitter_active(jact), .jitter_freq_eff(jf), .jitter_damp_eff(jd));
	host_pulse_model host_pulse_model_i (.mclk, .ref_pulse_pin(pls), .ref_dir_pin(dir),
		.deviation_clear_input(clr));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// net smoothed steps and run limit, sampled at the falling edge where outputs are settled
	always @(negedge mclk) begin
		if (pos_step === 1'b1) net <= net + (pos_dir ? 24'sd1 : -24'sd1);
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			miscompares = miscompares + 1;
			conclude();
		end
	end
	task automatic check_bit(input string what, input logic exp, input logic got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %b seen %b", what, exp, got);
		end
	endtask
	task automatic check_word(input string what, input logic [23:0] exp, input logic [23:0] got);
		samples_checked++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge mclk);
	endtask
	// motor feedback units; reverse adds to the deviation
	task automatic feed(input int n, input logic d);
		repeat (n) begin
			@(negedge mclk) fb_step = 1'b1;
			fb_dir = d;
			@(negedge mclk) fb_step = 1'b0;
		end
	endtask
	task automatic t_direct();
		base = net;
		host_pulse_model_i.send(3, 1'b1);
		idle(4);
		check_word("steps", 24'sd3, net - base);
		check_word("deviation", 24'sd3, dev);
		check_bit("done", 1'b0, done);
		// a new constant must wait while the deviation is not zero
		pcfg.ref_accel_time_const = 13'h0100;
		base = net;
		host_pulse_model_i.send(1, 1'b1);
		idle(1);
		check_word("steps deferred", 24'sd1, net - base);
		pcfg.ref_accel_time_const = TC_RESET;
		feed(4, 1'b1);
		idle(3);
		check_word("deviation", 24'sd0, dev);
		$display("direct test ended");
	endtask
	task automatic t_window();
		pcfg.done_width = 8'h02;
		pcfg.position_done_output_assign = 2'h2;
		feed(3, 1'b0);
		idle(3);
		check_bit("done", 1'b1, done);
		pcfg.done_width = 8'h03;
		idle(3);
		check_word("terms", 24'h00000b, {20'h0, terms});
		pcfg.mode = MODE_TORQUE;
		base = net;
		host_pulse_model_i.send(1, 1'b1);
		idle(4);
		check_word("terms", 24'h00000f, {20'h0, terms});
		check_word("steps", 24'sd0, net - base);
		pcfg.mode = MODE_POSITION;
		feed(3, 1'b1);
		$display("window test ended");
	endtask
	task automatic t_smooth();
		for (int k = 0; k < 2; k++) begin
			pcfg.second_order = k[0];
			pcfg.ref_accel_time_const = 13'h0003;
			idle(2);
			base = net;
			host_pulse_model_i.send(6, 1'b1);
			for (int i = 0; i < 400 && net - base != 24'sd6; i++) idle(1);
			check_word("steps", 24'sd6, net - base);
			feed(6, 1'b1);
		end
		pcfg.ref_accel_time_const = 13'h0000;
		$display("smoothing test ended");
	endtask
	task automatic t_inhibit();
		pcfg.mode = MODE_POS_INHIBIT;
		hold_n = 1'b0;
		idle(6);
		check_bit("clamp", 1'b1, clamp);
		base = net;
		host_pulse_model_i.send(2, 1'b1);
		idle(4);
		check_word("steps", 24'sd0, net - base);
		hold_n = 1'b1;
		idle(6);
		check_bit("clamp", 1'b0, clamp);
		host_pulse_model_i.send(2, 1'b0);
		idle(4);
		check_word("steps", -24'sd2, net - base);
		feed(2, 1'b0);
		host_pulse_model_i.send(2, 1'b1);
		host_pulse_model_i.clear_for(20001);
		idle(4);
		check_word("deviation", 24'sd0, dev);
		$display("inhibit and clear test ended");
	endtask
	task automatic jit_case(input logic en, input ctrl_mode_e m, input logic [9:0] f,
		input logic [7:0] d, input logic ea, input logic [9:0] ef, input logic [7:0] ed);
		jcfg = '{en, f, d};
		pcfg.mode = m;
		idle(2);
		check_bit("jitter active", ea, jact);
		check_word("jitter freq", {14'h0, ef}, {14'h0, jf});
		check_word("jitter damp", {16'h0, ed}, {16'h0, jd});
	endtask
	initial begin
		resetn = 1'b0;
		hold_n = 1'b1;
		fb_step = 1'b0;
		fb_dir = 1'b1;
		pcfg = '{MODE_POSITION, 1'b0, TC_RESET, DONE_W_RESET, 2'h0};
		jcfg = '{1'b0, JIT_FREQ_RESET, JIT_DAMP_RESET};
		miscompares = 0;
		samples_checked = 0;
		idle(3);
		check_bit("done in reset", 1'b1, done);
		resetn = 1'b1;
		idle(2);
		t_direct();
		t_window();
		t_smooth();
		t_inhibit();
		jit_case(1'b1, MODE_SPEED, 10'h005, 8'hff, 1'b1, 10'h00a, 8'hc8);
		jit_case(1'b1, MODE_TORQUE, 10'h3ff, 8'h19, 1'b0, 10'h3e8, 8'h19);
		jit_case(1'b0, MODE_POSITION, 10'h1f4, 8'h00, 1'b0, 10'h1f4, 8'h00);
		jit_case(1'b1, MODE_POS_INHIBIT, 10'h3e8, 8'hc8, 1'b1, 10'h3e8, 8'hc8);
		$display("jitter test ended");
		conclude();
	end
endmodule // testbench
